/* File: design/dtv_data_tenure.sv */
// data tenure valid, occupied and error signalling for one bus agent
// assumes bus pins are resolved outside; inputs synchronous to ref_clk
`timescale 1ns/1ps
`include "dtv_map.svh"
module dtv_data_tenure import dtv_pkg::*; #(
  parameter int MAX_BEATS = `DTV_MAX_BEATS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // transmit request side
  input wire logic tx_start,
  input wire logic [`DTV_CNT_W-1:0] tx_beats,
  input wire logic [`DTV_KIND_W-1:0] tx_kind,
  input wire logic tx_err_l1_parity,
  input wire logic tx_err_l2_uncorr,
  output logic tx_busy,
  output logic tx_beat_take,
  output logic tx_done,
  // receive side
  input wire logic rx_expect,
  output logic rx_beat,
  output logic rx_last,
  output logic rx_err_valid,
  output logic rx_err,
  // checkstop
  input wire logic checkstop_cond,
  output logic fatal_halt,
  // bus pins
  input wire logic data_bus_grant,
  input wire logic valid_line_primary_in,
  output logic valid_line_primary_out,
  output logic valid_line_primary_oe,
  input wire logic valid_line_alternate_in,
  output logic valid_line_alternate_out,
  output logic valid_line_alternate_oe,
  input wire logic data_bus_occupied_in,
  output logic data_bus_occupied_out,
  output logic data_bus_occupied_oe,
  input wire logic beat_error_flag_in,
  output logic beat_error_flag_out,
  output logic beat_error_flag_oe
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // refuse counts the beat counter cannot hold
  if (MAX_BEATS < 1 || MAX_BEATS >= (1 << `DTV_CNT_W)) begin : g_bad_beats
    $error("MAX_BEATS out of range for counter width");
  end

  localparam logic [`DTV_CNT_W-1:0] MAX_B = `DTV_CNT_W'(MAX_BEATS);
  localparam logic [`DTV_CNT_W-1:0] ONE_B = `DTV_CNT_W'(1);

  dtv_state_t s_q;
  dtv_state_t s_d;

  // clip a requested beat count into 1..MAX_BEATS
  function automatic logic [`DTV_CNT_W-1:0] clip_beats(
    input logic [`DTV_CNT_W-1:0] n
  );
    if (n == '0) begin
      clip_beats = ONE_B;
    end else if (n > MAX_B) begin
      clip_beats = MAX_B;
    end else begin
      clip_beats = n;
    end
  endfunction

  // ---------------------------------------------------------------
  // wire observations
  // ---------------------------------------------------------------
  logic driving;
  logic other_pri;
  logic any_valid;
  logic idle_ok;
  logic rx_ok;
  // own primary drive must not count as another master's use
  assign driving = s_q.pri_oe || s_q.alt_oe;
  assign other_pri = valid_line_primary_in && !s_q.pri_oe;
  assign any_valid = valid_line_primary_in || valid_line_alternate_in;
  // occupied negated this cycle and the one before
  assign idle_ok = !data_bus_occupied_in && s_q.occ_idle;
  assign rx_ok = rx_expect && !driving;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.take = 1'b0;
    s_d.done = 1'b0;
    // history of the primary line and the occupied wire
    s_d.pri_hist = other_pri;
    s_d.occ_idle = !data_bus_occupied_in;
    case (s_q.st)
      DTV_TX_IDLE: begin
        if (tx_start) begin
          s_d.st = DTV_TX_WAIT;
          s_d.left = clip_beats(tx_beats);
          s_d.err_en = (tx_kind == `DTV_KIND_PUSH) ||
                       (tx_kind == `DTV_KIND_COPYBACK);
        end
      end
      DTV_TX_WAIT: begin
        if (data_bus_grant && idle_ok) begin
          s_d.st = DTV_TX_SEND;
          // pick line once per tenure from the last two cycles
          s_d.alt_oe = other_pri || s_q.pri_hist;
          s_d.pri_oe = !(other_pri || s_q.pri_hist);
          s_d.alt_o = s_d.alt_oe;
          s_d.pri_o = s_d.pri_oe;
          s_d.occ_oe = 1'b1;
          s_d.occ_o = (s_q.left > ONE_B);
          s_d.left = s_q.left - ONE_B;
          s_d.take = 1'b1;
        end
      end
      DTV_TX_SEND: begin
        if (s_q.left == '0) begin
          // final beat is on the bus this cycle: drives are released at the next edge
          s_d.st = DTV_TX_IDLE;
          s_d.pri_oe = 1'b0;
          s_d.alt_oe = 1'b0;
          s_d.pri_o = 1'b0;
          s_d.alt_o = 1'b0;
          s_d.occ_oe = 1'b0;
          s_d.occ_o = 1'b0;
          s_d.done = 1'b1;
        end else begin
          // no stalls: the line stays put until the last beat
          s_d.occ_o = (s_q.left > ONE_B);
          s_d.left = s_q.left - ONE_B;
          s_d.take = 1'b1;
        end
      end
      default: begin
        s_d.st = DTV_TX_IDLE;
      end
    endcase
    s_d.busy = (s_d.st != DTV_TX_IDLE);
    // error answer two cycles behind each driven beat
    s_d.e1v = s_q.take;
    s_d.e1 = s_q.take && s_q.err_en &&
             (tx_err_l1_parity || tx_err_l2_uncorr);
    s_d.err_oe = s_q.e1v;
    s_d.err_o = s_q.e1;
    // receive: every cycle is looked at, quiet cycles are stalls
    s_d.rx_beat = rx_ok && any_valid;
    s_d.rx_last = rx_ok && any_valid && !data_bus_occupied_in;
    if (!rx_ok) begin
      s_d.rx_act = 1'b0;
    end else if (any_valid) begin
      s_d.rx_act = data_bus_occupied_in;
    end
    s_d.rx_p2 = s_q.rx_beat;
    s_d.rx_errv = s_q.rx_p2;
    s_d.rx_err = s_q.rx_p2 && beat_error_flag_in;
    // checkstop is sticky until reset
    s_d.halt = s_q.halt || checkstop_cond;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.st <= DTV_TX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign tx_busy = s_q.busy;
  assign tx_beat_take = s_q.take;
  assign tx_done = s_q.done;
  assign rx_beat = s_q.rx_beat;
  assign rx_last = s_q.rx_last;
  assign rx_err_valid = s_q.rx_errv;
  assign rx_err = s_q.rx_err;
  assign fatal_halt = s_q.halt;
  assign valid_line_primary_out = s_q.pri_o;
  assign valid_line_primary_oe = s_q.pri_oe;
  assign valid_line_alternate_out = s_q.alt_o;
  assign valid_line_alternate_oe = s_q.alt_oe;
  assign data_bus_occupied_out = s_q.occ_o;
  assign data_bus_occupied_oe = s_q.occ_oe;
  assign beat_error_flag_out = s_q.err_o;
  assign beat_error_flag_oe = s_q.err_oe;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  logic drv_valid;
  logic err_src;
  assign drv_valid = (s_q.pri_oe && s_q.pri_o) || (s_q.alt_oe && s_q.alt_o);
  assign err_src = tx_err_l1_parity || tx_err_l2_uncorr;

  sequence s_beat_out;
    drv_valid && data_bus_occupied_out;
  endsequence

  property p_hold_valid;
    s_beat_out |=> drv_valid;
  endproperty
  a_hold_valid: assert property (p_hold_valid)
    else $error("valid dropped inside tenure");

  property p_line_choice;
    $rose(driving) |-> valid_line_alternate_oe ==
      ($past(other_pri, 1) || $past(other_pri, 2));
  endproperty
  a_line_choice: assert property (p_line_choice)
    else $error("wrong valid line chosen");

  property p_line_fixed;
    valid_line_alternate_oe && data_bus_occupied_out |=>
      valid_line_alternate_oe && !valid_line_primary_oe;
  endproperty
  a_line_fixed: assert property (p_line_fixed)
    else $error("valid line switched inside tenure");

  property p_last_occupied;
    drv_valid && !data_bus_occupied_out |=> !driving;
  endproperty
  a_last_occupied: assert property (p_last_occupied)
    else $error("occupied negated before final cycle");

  property p_err_lag;
    drv_valid |-> ##2 beat_error_flag_oe;
  endproperty
  a_err_lag: assert property (p_err_lag)
    else $error("error flag not driven two cycles after valid");

  property p_err_cause;
    drv_valid && err_src && s_q.err_en |-> ##2 beat_error_flag_out;
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("cache error not flagged");

  property p_start_idle;
    $rose(data_bus_occupied_oe) |-> $past(data_bus_grant, 1) &&
      !$past(data_bus_occupied_in, 1) && !$past(data_bus_occupied_in, 2);
  endproperty
  a_start_idle: assert property (p_start_idle)
    else $error("tenure started without grant and idle bus");

  property p_rx_stall;
    rx_ok && !any_valid |=> !rx_beat;
  endproperty
  a_rx_stall: assert property (p_rx_stall)
    else $error("beat captured during stall");

  property p_rx_last;
    rx_ok && any_valid && !data_bus_occupied_in |=> rx_beat && rx_last;
  endproperty
  a_rx_last: assert property (p_rx_last)
    else $error("last beat not marked");

  property p_rx_err;
    rx_ok && any_valid |-> ##3 rx_err_valid &&
      rx_err == $past(beat_error_flag_in, 1);
  endproperty
  a_rx_err: assert property (p_rx_err)
    else $error("error flag not sampled two cycles after valid");

  property p_halt;
    checkstop_cond |=> fatal_halt [*2];
  endproperty
  a_halt: assert property (p_halt)
    else $error("checkstop did not raise fatal halt");

  property p_line_fixed_pri;
    valid_line_primary_oe && data_bus_occupied_out |=>
      valid_line_primary_oe && !valid_line_alternate_oe;
  endproperty
  a_line_fixed_pri: assert property (p_line_fixed_pri)
    else $error("primary line switched inside tenure");

  property p_occ_with_valid;
    data_bus_occupied_oe == drv_valid;
  endproperty
  a_occ_with_valid: assert property (p_occ_with_valid)
    else $error("occupied and valid drive out of step");

  property p_err_quiet;
    !drv_valid |-> ##2 !beat_error_flag_oe;
  endproperty
  a_err_quiet: assert property (p_err_quiet)
    else $error("error flag driven without a beat");

  property p_err_store;
    drv_valid && !(err_src && s_q.err_en) |-> ##2 !beat_error_flag_out;
  endproperty
  a_err_store: assert property (p_err_store)
    else $error("error flag raised on clean data");

  property p_rx_tenure;
    rx_last |-> !s_q.rx_act;
  endproperty
  a_rx_tenure: assert property (p_rx_tenure)
    else $error("receive tenure still open after last beat");

  property p_halt_hold;
    fatal_halt && !reset |=> fatal_halt;
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("fatal halt dropped without reset");

endmodule

/* File: design/dtv_map.svh */
// constants for the data tenure valid/termination block
// assumes one bus clock; all pin levels are active high logical values
//
// Functional notes
// - source holds valid from first cycle through last beat
// - use primary valid line when recently free
// - use alternate line after other primary use
// - line choice fixed within one tenure
// - either valid line marks a received beat
// - both lines negated mid-burst means stall
// - valid lines sampled every tenure cycle
// - termination follows each beat; last ends tenure
// - occupied asserted on all but final cycle
// - occupied negated on receive marks last beat
// - snoop push cache error drives error flag
// - copyback cache error drives error flag
// - error flag driven two cycles after valid
// - error flag sampled two cycles after valid
// - checkstop condition drives fatal halt output
// - start only after grant and two idle cycles
// - beats of one tag complete together (no tag is tracked here; each tenure's beats go out back to back)
`ifndef DTV_MAP_SVH
`define DTV_MAP_SVH
`define DTV_CNT_W 3
`define DTV_MAX_BEATS 4
`define DTV_ERR_LAG 2
`define DTV_PRI_LOOKBACK 2
`define DTV_IDLE_MIN 2
`define DTV_KIND_W 2
`define DTV_KIND_STORE 2'h0
`define DTV_KIND_PUSH 2'h1
`define DTV_KIND_COPYBACK 2'h2
`endif

/* File: design/dtv_pkg.sv */
// types shared by the data tenure block
// assumes dtv_map.svh is on the include path
`include "dtv_map.svh"
package dtv_pkg;
  typedef enum logic [1:0] {DTV_TX_IDLE, DTV_TX_WAIT, DTV_TX_SEND} dtv_tx_t;
  typedef struct packed {
    dtv_tx_t st;
    logic [`DTV_CNT_W-1:0] left;
    logic err_en;
    logic pri_hist;
    logic occ_idle;
    logic pri_o;
    logic pri_oe;
    logic alt_o;
    logic alt_oe;
    logic occ_o;
    logic occ_oe;
    logic take;
    logic e1;
    logic e1v;
    logic err_o;
    logic err_oe;
    logic busy;
    logic done;
    logic rx_act;
    logic rx_beat;
    logic rx_last;
    logic rx_p2;
    logic rx_errv;
    logic rx_err;
    logic halt;
  } dtv_state_t;
endpackage

/* File: dv/dtv_far_agent.sv */
// far-side bus master model: sources one data tenure on request
// assumes the bench resolves its drive with the device's onto the pins
`timescale 1ns/1ps
module dtv_far_agent (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // tenure request
  input wire logic go,
  input wire logic [2:0] beats,
  input wire logic use_alt,
  input wire logic [7:0] stall_mask,
  input wire logic [7:0] err_mask,
  // bus drive
  output logic pri,
  output logic alt,
  output logic occ,
  output logic err,
  output logic err_oe
);
  logic busy, v, eb, sel;
  logic [2:0] left;
  logic [3:0] k;
  logic [1:0] vp, ep;
  // one line per tenure; released lines read as pulled low
  assign pri = v & !sel;
  assign alt = v & sel;
  assign err = ep[1];
  assign err_oe = vp[1];
  // stalls drop both valid lines but keep occupied up
  always @(posedge ref_clk) begin
    if (reset) begin
      busy <= 1'b0;
      v <= 1'b0;
      occ <= 1'b0;
      vp <= 2'h0;
      ep <= 2'h0;
    end else begin
      vp <= {vp[0], v};
      ep <= {ep[0], eb};
      v <= 1'b0;
      occ <= 1'b0;
      if (go) begin
        busy <= 1'b1;
        left <= beats;
        sel <= use_alt;
        k <= 4'h0;
      end else if (busy) begin
        k <= k + 4'h1;
        if (k < 4'h8 && stall_mask[k[2:0]]) begin
          occ <= 1'b1;
        end else begin
          v <= 1'b1;
          occ <= (left > 3'h1);
          eb <= err_mask[beats - left];
          left <= left - 3'h1;
          busy <= (left > 3'h1);
        end
      end
    end
  end
endmodule

/* File: dv/tb_top.sv */
// self-checking bench for the data tenure block
// assumes the design package and map header are compiled first
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0, reset = 1'b1, tog = 1'b0;
  logic tx_start, tx_err_l1_parity, tx_err_l2_uncorr, rx_expect;
  logic checkstop_cond, data_bus_grant, f_go, f_alt;
  logic [2:0] tx_beats, f_beats;
  logic [1:0] tx_kind;
  logic [7:0] f_sm, f_em, rem;
  logic tx_busy, tx_beat_take, tx_done, rx_beat, rx_last;
  logic rx_err_valid, rx_err, fatal_halt, pri_o, pri_oe, alt_o, alt_oe;
  logic occ_o, occ_oe, err_o, err_oe, f_pri, f_altl, f_occ, f_err, f_eoe;
  logic p1, p2, e1, e2, k1, q1, q2, o1, o2, g1, line, done_seen;
  int bad_count = 0, total_checks = 0, cnt, exp_n, rn = 0, rc, ri = 0;
  int cur_kind;
  wire pri_w = (pri_o & pri_oe) | f_pri;
  wire alt_w = (alt_o & alt_oe) | f_altl;
  wire occ_w = (occ_o & occ_oe) | f_occ;
  // undriven error line wanders so a stale level never passes
  wire err_w = err_oe ? err_o : (f_eoe ? f_err : tog);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tog <= ~tog;
  dtv_data_tenure #(.MAX_BEATS(4)) u_dut (.ref_clk(ref_clk),
    .reset(reset), .tx_start(tx_start), .tx_beats(tx_beats),
    .tx_kind(tx_kind), .tx_err_l1_parity(tx_err_l1_parity),
    .tx_err_l2_uncorr(tx_err_l2_uncorr), .tx_busy(tx_busy),
    .tx_beat_take(tx_beat_take), .tx_done(tx_done), .rx_expect(rx_expect),
    .rx_beat(rx_beat), .rx_last(rx_last), .rx_err_valid(rx_err_valid),
    .rx_err(rx_err), .checkstop_cond(checkstop_cond),
    .fatal_halt(fatal_halt), .data_bus_grant(data_bus_grant),
    .valid_line_primary_in(pri_w), .valid_line_primary_out(pri_o),
    .valid_line_primary_oe(pri_oe), .valid_line_alternate_in(alt_w),
    .valid_line_alternate_out(alt_o), .valid_line_alternate_oe(alt_oe),
    .data_bus_occupied_in(occ_w), .data_bus_occupied_out(occ_o),
    .data_bus_occupied_oe(occ_oe), .beat_error_flag_in(err_w),
    .beat_error_flag_out(err_o), .beat_error_flag_oe(err_oe));
  dtv_far_agent u_far (.ref_clk(ref_clk), .reset(reset), .go(f_go),
    .beats(f_beats), .use_alt(f_alt), .stall_mask(f_sm), .err_mask(f_em),
    .pri(f_pri), .alt(f_altl), .occ(f_occ), .err(f_err), .err_oe(f_eoe));
  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // beats the device should send for a requested count
  function automatic int exp_beats(input logic [2:0] nb);
    if (nb == 3'h0) return 1;
    return (nb > 3'h4) ? 4 : int'(nb);
  endfunction
  // sampled mid-cycle so registered outputs have settled
  always @(negedge ref_clk) begin
    if (reset) begin
      {p1, p2, k1, q1, q2, o1, o2, g1} = 8'h0;
    end else begin
      chk(err_oe, p2);
      if (p2) chk(err_oe & err_o, e2);
      p2 = p1; e2 = e1;
      p1 = tx_beat_take;
      k1 = (cur_kind != 0);
      e1 = k1 & (tx_err_l1_parity | tx_err_l2_uncorr);
      if (tx_beat_take) begin
        if (cnt == 0) line = q1 | q2;
        if (cnt == 0) chk(g1 & !o1 & !o2, 1);
        chk({alt_oe & alt_o, pri_oe & pri_o}, line ? 2 : 1);
        chk({occ_oe, occ_oe & occ_o}, {1'b1, cnt + 1 < exp_n});
        chk(tx_busy, 1);
        cnt++;
      end
      if (tx_done) chk(8'(cnt), 8'(exp_n));
      if (tx_done) chk({tx_busy, pri_oe, alt_oe, occ_oe}, 8'h0);
      if (tx_done) done_seen = 1'b1;
      if (rx_beat) rc++;
      if (rx_beat) chk(rx_last, rc == rn);
      if (rx_err_valid) chk(rx_err, rem[ri]);
      if (rx_err_valid) ri++;
      q2 = q1; q1 = f_pri; o2 = o1; o1 = occ_w; g1 = data_bus_grant;
    end
  end
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  // other master pulses primary near our grant to steer line choice
  task automatic do_tx(input logic [2:0] nb, input logic [1:0] kd);
    int pd, gd, w;
    pd = $urandom_range(0, 5);
    gd = pd + 2 + $urandom_range(0, 3);
    exp_n = exp_beats(nb);
    cur_kind = kd; cnt = 0; done_seen = 1'b0; w = 0;
    @(posedge ref_clk);
    tx_start <= 1'b1; tx_beats <= nb; tx_kind <= kd;
    while (!done_seen && w < 60) begin
      @(posedge ref_clk);
      // a second request while busy must be ignored
      tx_start <= (w == 1); tx_beats <= 3'h1;
      data_bus_grant <= (w >= gd);
      f_go <= (w == pd); f_beats <= 3'h1; f_alt <= 1'b0;
      f_sm <= 8'h00; f_em <= 8'h00;
      tx_err_l1_parity <= 1'($urandom);
      tx_err_l2_uncorr <= ($urandom_range(0, 3) == 0);
      w++;
    end
    chk(done_seen, 1);
    @(posedge ref_clk);
    data_bus_grant <= 1'b0;
  endtask
  task automatic do_rx(input logic [2:0] nb, input logic al,
                       input logic [7:0] sm, input logic [7:0] em);
    int w;
    rn = nb; rc = 0; ri = 0; rem = em; w = 0;
    @(posedge ref_clk);
    rx_expect <= 1'b1; f_go <= 1'b1; f_beats <= nb; f_alt <= al;
    f_sm <= sm; f_em <= em;
    @(posedge ref_clk);
    f_go <= 1'b0;
    while (ri < rn && w < 60) begin
      @(posedge ref_clk);
      w++;
    end
    rx_expect <= 1'b0;
    chk(8'(rc), 8'(rn));
    chk(8'(ri), 8'(rn));
  endtask
  initial begin
    {tx_start, tx_beats, tx_kind, tx_err_l1_parity, tx_err_l2_uncorr} = 0;
    {rx_expect, checkstop_cond, data_bus_grant, f_go, f_alt} = 5'h0;
    {f_beats, f_sm, f_em} = 0;
    void'($urandom(32'h71F5));
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk({tx_busy, pri_oe, alt_oe, occ_oe, err_oe, fatal_halt}, 0);
    do_tx(3'h0, 2'h1);
    do_tx(3'h7, 2'h2);
    do_tx(3'h4, 2'h0);
    repeat (16) do_tx(3'($urandom_range(1, 4)), 2'($urandom_range(0, 2)));
    do_rx(3'h4, 1'b0, 8'h0A, 8'h05);
    repeat (16) do_rx(3'($urandom_range(1, 4)), 1'($urandom),
                      8'($urandom) & 8'hFE, 8'($urandom));
    @(posedge ref_clk);
    checkstop_cond <= 1'b1;
    @(posedge ref_clk);
    checkstop_cond <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(fatal_halt, 1);
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk(fatal_halt, 0);
    report_and_stop;
  end
  // hang guard well beyond the expected few hundred cycles
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
endmodule
